// ==== hw/mpt_defines.svh ====
// register offsets, field positions, reset values of the motor pwm timer
// assumes an apb slave with byte addresses on paddr[7:0]
`ifndef MPT_DEFINES_SVH
`define MPT_DEFINES_SVH

`define MPT_A_CTRL      8'h00
`define MPT_A_PRESC     8'h04
`define MPT_A_RELOAD    8'h08
`define MPT_A_COUNT     8'h0c
`define MPT_A_CHCFG     8'h10
`define MPT_A_DEAD      8'h14
`define MPT_A_CCR0      8'h18
`define MPT_A_STATUS    8'h28
`define MPT_A_MASK      8'h2c
`define MPT_A_DMAEN     8'h30

`define MPT_NCH         4
`define MPT_ST_UPD      0
`define MPT_ST_CC0      1
`define MPT_ST_W        5

`define MPT_RELOAD_RST  16'hffff
`define MPT_PRESC_RST   16'h0000
`define MPT_DEAD_RST    8'h00

`endif

// ==== hw/mpt_pkg.sv ====
// types shared by the motor pwm timer and its channel slice
// assumes mpt_defines.svh is on the include path
`include "mpt_defines.svh"

package mpt_pkg;

    typedef enum logic [1:0] {MPT_UP, MPT_DOWN, MPT_CENTER} mpt_count_t;
    typedef enum logic [1:0] {MPT_BASIC, MPT_GENERAL, MPT_ADVANCED} mpt_kind_t;
    typedef enum logic [1:0] {MPT_TRIG_OFF, MPT_TRIG_RESTART,
                              MPT_TRIG_CLOCK} mpt_trig_t;
    typedef enum logic [1:0] {MPT_CH_OFF, MPT_CH_CAPTURE, MPT_CH_TOGGLE,
                              MPT_CH_PWM} mpt_chmode_t;

    // control register, bit 0 is en
    typedef struct packed {
        mpt_trig_t  trig;
        mpt_kind_t  kind;
        logic       comp;
        logic       freeze;
        logic       opm;
        mpt_count_t mode;
        logic       en;
    } mpt_ctrl_t;

    typedef struct packed {
        logic        pol;
        mpt_chmode_t mode;
    } mpt_chcfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mpt_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mpt_apb_rsp_t;

    typedef struct packed {
        logic update_trig;
        logic adc_regular;
        logic adc_inject;
        logic link_out;
    } mpt_evt_t;

    typedef struct packed {
        logic [2:0] sync;
        logic       filt;
        logic       ref_lvl;
        logic [7:0] dt;
        logic       out;
        logic       out_n;
        logic       cap_ev;
        logic       cmp_ev;
    } mpt_ch_state_t;

    typedef struct packed {
        mpt_ctrl_t              ctrl;
        logic [15:0]            presc;
        logic [15:0]            reload;
        logic [15:0]            cnt;
        logic [15:0]            psc;
        logic                   dir;
        mpt_chcfg_t [3:0]       chcfg;
        logic [7:0]             dead;
        logic [3:0][15:0]       ccr;
        logic [`MPT_ST_W-1:0]   st;
        logic [`MPT_ST_W-1:0]   mask;
        logic [`MPT_ST_W-1:0]   dmaen;
        logic                   irq;
        logic [`MPT_ST_W-1:0]   dma;
        mpt_evt_t               evt;
        mpt_apb_rsp_t           rsp;
    } mpt_state_t;

endpackage : mpt_pkg

// ==== hw/mpt_channel.sv ====
// one capture/compare channel with dead-time and complementary output
// assumes cap_pin is asynchronous; cnt, ccr and tick come from sys_clk
`timescale 1ns/10ps

module mpt_channel (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               tick,
    input  wire logic [15:0]        cnt,
    input  wire logic [15:0]        ccr,
    input  mpt_pkg::mpt_chcfg_t     cfg,
    input  wire logic               comp_en,
    input  wire logic [7:0]         dead,
    input  wire logic               cap_pin,
    output logic                    out,
    output logic                    out_n,
    output logic                    cap_ev,
    output logic                    cmp_ev
);
    import mpt_pkg::*;

    mpt_ch_state_t c_r;
    mpt_ch_state_t c_nxt;
    logic          match;

    always_comb begin
        c_nxt = c_r;
        match = tick && (cnt == ccr);
        c_nxt.sync = {c_r.sync[1:0], cap_pin};
        // level moves only when stages two and three agree
        if (c_r.sync[1] == c_r.sync[2]) begin
            c_nxt.filt = c_r.sync[2];
        end
        c_nxt.cap_ev = (cfg.mode == MPT_CH_CAPTURE) &&
                       (c_nxt.filt != c_r.filt) &&
                       (c_nxt.filt != cfg.pol);
        c_nxt.cmp_ev = match && (cfg.mode == MPT_CH_TOGGLE ||
                                 cfg.mode == MPT_CH_PWM);
        unique case (cfg.mode)
            MPT_CH_TOGGLE: begin
                if (match) begin
                    c_nxt.ref_lvl = ~c_r.ref_lvl;
                end
            end
            // ccr 0 is always off, ccr above reload always on
            MPT_CH_PWM:    c_nxt.ref_lvl = (cnt < ccr) ^ cfg.pol;
            default:       c_nxt.ref_lvl = cfg.pol;
        endcase
        // both sides idle for dead cycles after each reference edge
        if (c_nxt.ref_lvl != c_r.ref_lvl) begin
            c_nxt.dt = dead;
        end else if (c_r.dt != 8'h00) begin
            c_nxt.dt = c_r.dt - 8'h01;
        end
        if (comp_en) begin
            c_nxt.out   = c_nxt.ref_lvl & (c_nxt.dt == 8'h00);
            c_nxt.out_n = ~c_nxt.ref_lvl & (c_nxt.dt == 8'h00);
        end else begin
            c_nxt.out   = c_nxt.ref_lvl;
            c_nxt.out_n = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign out    = c_r.out;
    assign out_n  = c_r.out_n;
    assign cap_ev = c_r.cap_ev;
    assign cmp_ev = c_r.cmp_ev;

endmodule : mpt_channel

// ==== hw/mpt_timer.sv ====
// motor pwm timer: one 16-bit timer that software sets up as basic,
// general-purpose or advanced, with four channels and an apb slave
// assumes apb master on sys_clk; link_in comes from a sibling timer on
// the same clock; dbg_halt is the core's halted level, same clock
//
// Notes on behaviour
// - the counter is 16 bits, reloads by itself and counts up, down or center.
// - a 16-bit prescaler divides the counter clock by presc plus one.
// - four channels each do capture, compare, pwm or one-pulse output.
// - the advanced kind has the same four channels with edge or center pwm.
// - complementary pairs get a programmable dead-time at each switch.
// - three channel pairs give the six outputs of a three-phase bridge.
// - pwm duty reaches from always off to always on.
// - the advanced kind without complement acts as a general-purpose timer, except that its events start adc injection.
// - with freeze set the counter stops while the core is halted in debug.
// - update goes out to other timers and their events restart or clock us.
// - each timer raises its own dma requests from its own events.
// - the basic kind counts up only and has its channels turned off.
// - only the advanced kind drives complementary outputs.
// - update events trigger the dac and also raise a dma request.
// - general kind events start adc regular, advanced ones adc injection.
`timescale 1ns/10ps

module mpt_timer (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  mpt_pkg::mpt_apb_req_t   apb_req,
    output mpt_pkg::mpt_apb_rsp_t   apb_rsp,
    input  wire logic               dbg_halt,
    input  wire logic               link_in,
    input  wire logic [3:0]         cap_pin,
    output logic [3:0]              pwm_out,
    output logic [3:0]              pwm_out_n,
    output logic                    irq,
    output logic [4:0]              dma_req,
    output mpt_pkg::mpt_evt_t       evt
);
    import mpt_pkg::*;

    mpt_state_t             s_r;
    mpt_state_t             s_nxt;
    mpt_chcfg_t [3:0]       cfg_eff;
    logic                   comp_en;
    logic [3:0]             cap_ev;
    logic [3:0]             cmp_ev;
    logic                   tick;
    logic                   run;
    logic                   upd;
    logic                   setup;
    logic                   wr;
    mpt_count_t             cmode;
    logic [`MPT_ST_W-1:0]   set;
    logic [`MPT_ST_W-1:0]   clr;
    logic [31:0]            wd;

    function automatic logic mpt_hit(input logic [7:0] a);
        logic ok;
        ok = (a == `MPT_A_CTRL)   || (a == `MPT_A_PRESC) ||
             (a == `MPT_A_RELOAD) || (a == `MPT_A_COUNT) ||
             (a == `MPT_A_CHCFG)  || (a == `MPT_A_DEAD)  ||
             (a == `MPT_A_STATUS) || (a == `MPT_A_MASK)  ||
             (a == `MPT_A_DMAEN);
        for (int i = 0; i < `MPT_NCH; i++) begin
            if (a == `MPT_A_CCR0 + 8'(4 * i)) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction : mpt_hit

    function automatic logic [31:0] mpt_read(input mpt_state_t s,
                                             input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            `MPT_A_CTRL:   d = 32'(s.ctrl);
            `MPT_A_PRESC:  d = {16'h0000, s.presc};
            `MPT_A_RELOAD: d = {16'h0000, s.reload};
            `MPT_A_COUNT:  d = {16'h0000, s.cnt};
            `MPT_A_CHCFG:  d = 32'(s.chcfg);
            `MPT_A_DEAD:   d = {24'h000000, s.dead};
            `MPT_A_STATUS: d = 32'(s.st);
            `MPT_A_MASK:   d = 32'(s.mask);
            `MPT_A_DMAEN:  d = 32'(s.dmaen);
            default: begin
                for (int i = 0; i < `MPT_NCH; i++) begin
                    if (a == `MPT_A_CCR0 + 8'(4 * i)) begin
                        d = {16'h0000, s.ccr[i]};
                    end
                end
            end
        endcase
        return d;
    endfunction : mpt_read

    // channel modes are forced off on the basic kind
    always_comb begin
        for (int i = 0; i < `MPT_NCH; i++) begin
            cfg_eff[i] = s_r.chcfg[i];
            if (s_r.ctrl.kind == MPT_BASIC) begin
                cfg_eff[i] = '0;
            end
        end
    end

    assign comp_en = s_r.ctrl.comp &&
                     (s_r.ctrl.kind == MPT_ADVANCED);

    for (genvar g = 0; g < `MPT_NCH; g++) begin : g_ch
        mpt_channel u_ch (
            .sys_clk (sys_clk),
            .rst     (rst),
            .tick    (tick),
            .cnt     (s_r.cnt),
            .ccr     (s_r.ccr[g]),
            .cfg     (cfg_eff[g]),
            .comp_en (comp_en),
            .dead    (s_r.dead),
            .cap_pin (cap_pin[g]),
            .out     (pwm_out[g]),
            .out_n   (pwm_out_n[g]),
            .cap_ev  (cap_ev[g]),
            .cmp_ev  (cmp_ev[g])
        );
    end

    always_comb begin
        s_nxt = s_r;
        upd   = 1'b0;
        tick  = 1'b0;
        clr   = '0;
        wd    = apb_req.pwdata;
        setup = apb_req.psel & ~apb_req.penable;
        wr    = apb_req.psel & apb_req.penable & apb_req.pwrite &
                s_r.rsp.pready & mpt_hit(apb_req.paddr);

        // halted core freezes prescaler and counter alike
        run   = s_r.ctrl.en & ~(s_r.ctrl.freeze & dbg_halt);
        cmode = (s_r.ctrl.kind == MPT_BASIC) ? MPT_UP
                                             : s_r.ctrl.mode;

        if (run) begin
            if (s_r.ctrl.trig == MPT_TRIG_CLOCK) begin
                tick = link_in;
            // a count left above a smaller new divider wraps at once
            end else if (s_r.psc >= s_r.presc) begin
                s_nxt.psc = 16'h0000;
                tick      = 1'b1;
            end else begin
                s_nxt.psc = s_r.psc + 16'h0001;
            end
        end

        if (tick) begin
            unique case (cmode)
                MPT_UP: begin
                    if (s_r.cnt >= s_r.reload) begin
                        s_nxt.cnt = 16'h0000;
                        upd       = 1'b1;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
                MPT_DOWN: begin
                    if (s_r.cnt == 16'h0000) begin
                        s_nxt.cnt = s_r.reload;
                        upd       = 1'b1;
                    end else begin
                        s_nxt.cnt = s_r.cnt - 16'h0001;
                    end
                end
                MPT_CENTER: begin
                    if (!s_r.dir && s_r.cnt >= s_r.reload) begin
                        s_nxt.dir = 1'b1;
                        s_nxt.cnt = (s_r.reload == 16'h0000) ? 16'h0000
                                  : s_r.reload - 16'h0001;
                        upd       = 1'b1;
                    end else if (s_r.dir && s_r.cnt == 16'h0000) begin
                        s_nxt.dir = 1'b0;
                        s_nxt.cnt = (s_r.reload == 16'h0000) ? 16'h0000
                                  : 16'h0001;
                        upd       = 1'b1;
                    end else if (s_r.dir) begin
                        s_nxt.cnt = s_r.cnt - 16'h0001;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
                default: s_nxt.cnt = s_r.cnt;
            endcase
        end

        // one-pulse: counting stops at update, channel outputs keep following the stopped count
        if (upd && s_r.ctrl.opm) begin
            s_nxt.ctrl.en = 1'b0;
        end

        // link restart: rearm and start, a sibling update lines us up
        if (s_r.ctrl.trig == MPT_TRIG_RESTART && link_in) begin
            s_nxt.cnt     = (cmode == MPT_DOWN) ? s_r.reload
                                                : 16'h0000;
            s_nxt.psc     = 16'h0000;
            s_nxt.dir     = 1'b0;
            s_nxt.ctrl.en = 1'b1;
        end

        // capture stores the count seen when the filtered edge lands
        for (int i = 0; i < `MPT_NCH; i++) begin
            if (cap_ev[i]) begin
                s_nxt.ccr[i] = s_r.cnt;
            end
        end

        set = {cap_ev | cmp_ev, upd};

        // software writes win over the counter and over hardware en clear
        if (wr) begin
            unique case (apb_req.paddr)
                `MPT_A_CTRL:   s_nxt.ctrl   = mpt_ctrl_t'(wd[9:0]);
                `MPT_A_PRESC:  s_nxt.presc  = wd[15:0];
                `MPT_A_RELOAD: s_nxt.reload = wd[15:0];
                `MPT_A_COUNT:  s_nxt.cnt    = wd[15:0];
                `MPT_A_CHCFG:  s_nxt.chcfg  = wd[11:0];
                `MPT_A_DEAD:   s_nxt.dead   = wd[7:0];
                `MPT_A_STATUS: clr          = wd[`MPT_ST_W-1:0];
                `MPT_A_MASK:   s_nxt.mask   = wd[`MPT_ST_W-1:0];
                `MPT_A_DMAEN:  s_nxt.dmaen  = wd[`MPT_ST_W-1:0];
                default: begin
                    for (int i = 0; i < `MPT_NCH; i++) begin
                        if (apb_req.paddr == `MPT_A_CCR0 + 8'(4 * i)) begin
                            s_nxt.ccr[i] = wd[15:0];
                        end
                    end
                end
            endcase
        end

        // a flag set in the clearing cycle stays set
        s_nxt.st  = (s_r.st & ~clr) | set;
        s_nxt.irq = |(s_nxt.st & s_r.mask);
        s_nxt.dma = set & s_r.dmaen;

        s_nxt.evt.update_trig = upd;
        s_nxt.evt.link_out    = upd;
        s_nxt.evt.adc_regular = (s_r.ctrl.kind == MPT_GENERAL) &&
                                (upd || cmp_ev[0]);
        s_nxt.evt.adc_inject  = (s_r.ctrl.kind == MPT_ADVANCED) &&
                                (upd || cmp_ev[0]);

        // zero-wait slave: data is latched in setup, ready in access
        s_nxt.rsp.pready  = setup;
        s_nxt.rsp.pslverr = setup & ~mpt_hit(apb_req.paddr);
        s_nxt.rsp.prdata  = (setup & ~apb_req.pwrite)
                          ? mpt_read(s_r, apb_req.paddr) : 32'h0000_0000;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r        <= '0;
            s_r.reload <= `MPT_RELOAD_RST;
            s_r.presc  <= `MPT_PRESC_RST;
            s_r.dead   <= `MPT_DEAD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp = s_r.rsp;
    assign irq     = s_r.irq;
    assign dma_req = s_r.dma;
    assign evt     = s_r.evt;

endmodule : mpt_timer

// ==== verification/mpt_pin_model.sv ====
// capture source model driving the timer's capture pins
// assumes the bench sets cap_lvl on sys_clk
`timescale 1ns/10ps

module mpt_pin_model (
    input  wire logic       sys_clk,
    input  wire logic [3:0] cap_lvl,
    output logic [3:0]      cap_pin
);
    initial cap_pin = 4'h0;
    // a real source is unrelated to our clock, so move off the rising edge
    always @(negedge sys_clk) cap_pin <= cap_lvl;
endmodule : mpt_pin_model

// ==== verification/mpt_timer_sva.sv ====
// port checker of the motor pwm timer
// assumes a bind to mpt_timer; one clock, synchronous reset
`timescale 1ns/10ps
`include "mpt_defines.svh"

module mpt_timer_sva (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  mpt_pkg::mpt_apb_req_t apb_req,
    input  mpt_pkg::mpt_apb_rsp_t apb_rsp,
    input  wire logic             dbg_halt,
    input  wire logic             link_in,
    input  wire logic [3:0]       cap_pin,
    input  wire logic [3:0]       pwm_out,
    input  wire logic [3:0]       pwm_out_n,
    input  wire logic             irq,
    input  wire logic [4:0]       dma_req,
    input  mpt_pkg::mpt_evt_t     evt
);
    import mpt_pkg::*;
    logic wr;
    logic adv_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready
              & apb_req.pwrite;
    // last control word written: advanced kind with complement on
    always_ff @(posedge sys_clk) begin
        if (rst)
            adv_r <= 1'b0;
        else if (wr && apb_req.paddr == `MPT_A_CTRL)
            adv_r <= apb_req.pwdata[7:6] == 2'h2 && apb_req.pwdata[5];
    end
    AST_APB_ZERO_WAIT: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("pready missing in access cycle");
    AST_APB_ONE_CYCLE: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held too long");
    AST_APB_ERR_READY: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    AST_APB_UNMAPPED: assert property (apb_req.psel && !apb_req.penable
        && apb_req.paddr[7:6] != 2'h0 |=> apb_rsp.pslverr)
        else $error("unmapped access not refused");
    AST_APB_IDLE_DATA: assert property (
        !apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
        else $error("read data outside access");
    AST_DEAD_NO_OVERLAP: assert property (
        (pwm_out & pwm_out_n) == 4'h0)
        else $error("pair driven high together");
    AST_COMP_ONLY_ADV: assert property (
        (!adv_r) [*3] |-> pwm_out_n == 4'h0)
        else $error("complement active outside advanced kind");
    AST_LINK_IS_UPDATE: assert property (
        evt.update_trig == evt.link_out)
        else $error("link and dac trigger differ");
    AST_ADC_EXCLUSIVE: assert property (
        !(evt.adc_regular && evt.adc_inject))
        else $error("both adc triggers at once");
    AST_MASK_DROPS_IRQ: assert property (
        wr && apb_req.paddr == `MPT_A_MASK && apb_req.pwdata[4:0] == 5'h0
        |=> ##1 !irq)
        else $error("irq stays after full mask");
endmodule : mpt_timer_sva

// ==== verification/mpt_timer_bench.sv ====
// self-checking bench of the motor pwm timer over apb
// assumes package, design, pin model and checker compiled first
`timescale 1ns/10ps
`include "mpt_defines.svh"

module mpt_timer_bench;
    import mpt_pkg::*;
    logic         sys_clk;
    logic         rst;
    mpt_apb_req_t req;
    mpt_apb_rsp_t rsp;
    logic         dbg_halt;
    logic         link_in;
    logic [3:0]   cap_lvl;
    logic [3:0]   cap_pin;
    logic [3:0]   pwm_out;
    logic [3:0]   pwm_out_n;
    logic         irq;
    logic [4:0]   dma_req;
    mpt_evt_t     evt;
    int           err_count;
    int           compares;
    logic [31:0]  q;
    logic [31:0]  v;
    logic         e;
    int           n;
    int           h;
    int           lo;
    int           hn;
    int           ctl [5] = '{'h41, 'h41, 'h43, 'h45, 'h05};
    int           psc [5] = '{0, 2, 0, 0, 0};
    int           gp  [5] = '{5, 15, 5, 4, 5};

    mpt_timer i_dut (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .apb_req   (req),
        .apb_rsp   (rsp),
        .dbg_halt  (dbg_halt),
        .link_in   (link_in),
        .cap_pin   (cap_pin),
        .pwm_out   (pwm_out),
        .pwm_out_n (pwm_out_n),
        .irq       (irq),
        .dma_req   (dma_req),
        .evt       (evt)
    );
    mpt_pin_model i_pins (
        .sys_clk (sys_clk),
        .cap_lvl (cap_lvl),
        .cap_pin (cap_pin)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : cyc

    // one apb transfer; read data and error are taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        if (rsp.pready !== 1'b1) err_count++;
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd_chk

    // cycles between two update pulses
    task automatic gap(input logic ar, output int g);
        int k;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (evt.update_trig !== 1'b1 && k < 200);
        check({31'h0, dma_req[0]}, 32'h1);
        check({31'h0, evt.link_out}, 32'h1);
        check({31'h0, evt.adc_regular}, {31'h0, ar});
        g = 0;
        do begin
            @(negedge sys_clk);
            g++;
        end while (evt.update_trig !== 1'b1 && g < 200);
    endtask : gap

    // counts over 30 cycles, three whole pwm periods of ten
    task automatic sample(output int hi, output int low2, output int hin);
        hi = 0;
        low2 = 0;
        hin = 0;
        cyc(10);
        repeat (30) begin
            @(negedge sys_clk);
            hi += pwm_out[0];
            hin += pwm_out_n[0];
            low2 += !pwm_out[0] && !pwm_out_n[0];
        end
    endtask : sample

    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    initial begin
        #(40 * 30000);
        err_count++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        dbg_halt = 1'b0;
        link_in = 1'b0;
        cap_lvl = 4'h0;
        err_count = 0;
        compares = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`MPT_A_CTRL, 32'h0);
        rd_chk(`MPT_A_RELOAD, 32'hffff);
        rd_chk(`MPT_A_PRESC, 32'h0);
        rd_chk(`MPT_A_DEAD, 32'h0);
        apb(1'b1, 8'h40, 32'h1);
        check({31'h0, e}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        apb(1'b1, `MPT_A_DMAEN, 32'h1);
        apb(1'b1, `MPT_A_RELOAD, 32'h4);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `MPT_A_CTRL, 32'h0);
            apb(1'b1, `MPT_A_PRESC, psc[i]);
            apb(1'b1, `MPT_A_CTRL, ctl[i]);
            gap(ctl[i][7:6] == 2'h1, n);
            check(n, gp[i]);
        end
        // the table leaves the counter running as a basic time base
        apb(1'b1, `MPT_A_MASK, 32'h1);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        check(irq, 32'h1);
        apb(1'b1, `MPT_A_MASK, 32'h0);
        cyc(1);
        @(negedge sys_clk);
        check(irq, 32'h0);
        apb(1'b1, `MPT_A_CTRL, 32'h0);
        apb(1'b1, `MPT_A_STATUS, 32'h1f);
        rd_chk(`MPT_A_STATUS, 32'h0);
        apb(1'b1, `MPT_A_RELOAD, 32'h9);
        apb(1'b1, `MPT_A_CHCFG, 32'h3);
        apb(1'b1, `MPT_A_CTRL, 32'h41);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `MPT_A_CCR0, 5 * i);
            sample(h, lo, hn);
            check(h, 15 * i);
        end
        apb(1'b1, `MPT_A_CCR0, 32'h5);
        apb(1'b1, `MPT_A_DEAD, 32'h2);
        apb(1'b1, `MPT_A_CTRL, 32'ha1);
        sample(h, lo, hn);
        check(lo, 12);
        check(hn, 9);
        apb(1'b1, `MPT_A_CTRL, 32'h61);
        sample(h, lo, hn);
        check(hn, 0);
        apb(1'b1, `MPT_A_CHCFG, 32'hb);
        apb(1'b1, `MPT_A_STATUS, 32'h1f);
        cap_lvl <= 4'h2;
        cyc(12);
        apb(1'b0, `MPT_A_STATUS, 32'h0);
        check(q & 32'h4, 32'h4);
        apb(1'b1, `MPT_A_RELOAD, 32'hffff);
        dbg_halt <= 1'b1;
        apb(1'b1, `MPT_A_CTRL, 32'h51);
        apb(1'b0, `MPT_A_COUNT, 32'h0);
        v = q;
        cyc(5);
        rd_chk(`MPT_A_COUNT, v);
        dbg_halt <= 1'b0;
        cyc(5);
        apb(1'b0, `MPT_A_COUNT, 32'h0);
        check({31'h0, q != v}, 32'h1);
        apb(1'b1, `MPT_A_CTRL, 32'h0);
        apb(1'b1, `MPT_A_RELOAD, 32'h3);
        apb(1'b1, `MPT_A_CTRL, 32'h49);
        cyc(20);
        rd_chk(`MPT_A_CTRL, 32'h48);
        rd_chk(`MPT_A_COUNT, 32'h0);
        apb(1'b1, `MPT_A_CTRL, 32'h140);
        link_in <= 1'b1;
        @(posedge sys_clk);
        link_in <= 1'b0;
        cyc(2);
        rd_chk(`MPT_A_CTRL, 32'h141);
        wrap_up();
    end
endmodule : mpt_timer_bench

bind mpt_timer mpt_timer_sva i_sva (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .apb_req   (apb_req),
    .apb_rsp   (apb_rsp),
    .dbg_halt  (dbg_halt),
    .link_in   (link_in),
    .cap_pin   (cap_pin),
    .pwm_out   (pwm_out),
    .pwm_out_n (pwm_out_n),
    .irq       (irq),
    .dma_req   (dma_req),
    .evt       (evt)
);
